// File: pkg/pae_pkg.sv
// Constants, field layout and types for the PHY addressing and 4B/5B block.
// Assumes a 32-bit Avalon-MM register window with byte addresses.
package pae_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Register offsets (byte addresses)
  localparam logic [7:0] OFF_BCR [2] = '{8'h00, 8'h08};
  localparam logic [7:0] OFF_SMR [2] = '{8'h04, 8'h0C};
  localparam logic [7:0] OFF_ADDR    = 8'h10;
  localparam logic [7:0] OFF_STAT    = 8'h14;

  //////////////////////////////////////////////////////////////////////////////
  // Field positions and reset values
  localparam int          BCR_SPD_BIT  = 13;
  localparam int          BCR_DPX_BIT  = 8;
  localparam logic [15:0] BCR_RST      = 16'h3100;
  localparam int          PADDR_W      = 5;
  localparam int          ADDR_V_LSB   = 0;
  localparam int          ADDR_P1_LSB  = 8;
  localparam int          ADDR_P2_LSB  = 16;
  localparam int          ADDR_STRAP   = 24;
  localparam int          STAT_ST_LSB  = 0;
  localparam int          STAT_RDY_BIT = 4;
  localparam logic [4:0]  VADDR_BASE   = 5'h00;
  localparam logic [4:0]  PADDR_BASE [2] = '{5'h01, 5'h02};

  //////////////////////////////////////////////////////////////////////////////
  // FIFO entry: {tx_en, tx_er, nibble}
  localparam int FE_W  = 6;
  localparam int FE_EN = 5;
  localparam int FE_ER = 4;

  //////////////////////////////////////////////////////////////////////////////
  // Code-groups
  localparam logic [4:0] CG_DATA [16] = '{
    5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
    5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
  localparam logic [4:0] CG_I = 5'h1F;
  localparam logic [4:0] CG_J = 5'h18;
  localparam logic [4:0] CG_K = 5'h11;
  localparam logic [4:0] CG_T = 5'h0D;
  localparam logic [4:0] CG_R = 5'h07;
  localparam logic [4:0] CG_H = 5'h04;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_SSD  = 2'h1,
    ST_DATA = 2'h2,
    ST_ESD  = 2'h3
  } pae_state_t;

  typedef enum logic [2:0] {
    SYM_I    = 3'h0,
    SYM_J    = 3'h1,
    SYM_K    = 3'h2,
    SYM_T    = 3'h3,
    SYM_R    = 3'h4,
    SYM_H    = 3'h5,
    SYM_DATA = 3'h6,
    SYM_RAW  = 3'h7
  } pae_sym_t;

endpackage

// File: core/pae_fifo.sv
// Synchronous FIFO, flip-flop storage, valid/ready on both sides.
// Assumes one clock; in_ready_o is registered and exact.
`timescale 1ns/100ps
`default_nettype none
module pae_fifo #(
  parameter int W = 6,
  parameter int D = 16
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = $clog2(D);

  generate
    if (W < 1 || D < 2 || (1 << AW) != D) begin : g_bad
      $error("pae_fifo: depth must be a power of two, at least 2");
    end
  endgenerate

  logic [W-1:0]  mem_r [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0]   cnt_r;
  logic [AW:0]   cnt_nxt;
  logic          push;
  logic          pop;

  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o  = mem_r[rp_r];

  always_comb begin
    cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wp_r] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wp_r       <= '0;
      rp_r       <= '0;
      cnt_r      <= '0;
      in_ready_o <= 1'b1;
    end else begin
      wp_r       <= wp_r + AW'(push);
      rp_r       <= rp_r + AW'(pop);
      cnt_r      <= cnt_nxt;
      in_ready_o <= (cnt_nxt != (AW+1)'(D));
    end
  end
endmodule
`default_nettype wire

// File: core/pae_enc.sv
// Symbol selector: maps a symbol kind and nibble to a 5-bit code-group.
// Purely combinational; the caller registers the result.
`timescale 1ns/100ps
`default_nettype none
module pae_enc
  import pae_pkg::*;
(
  input  wire pae_sym_t   kind_i,
  input  wire logic [3:0] nib_i,
  output logic [4:0]      code_o
);
  always_comb begin
    unique case (kind_i)
      SYM_I:    code_o = CG_I;
      SYM_J:    code_o = CG_J;
      SYM_K:    code_o = CG_K;
      SYM_T:    code_o = CG_T;
      SYM_R:    code_o = CG_R;
      SYM_H:    code_o = CG_H;
      SYM_DATA: code_o = CG_DATA[nib_i];
      SYM_RAW:  code_o = {1'b0, nib_i};
    endcase
  end
endmodule
`default_nettype wire

// File: core/pae_top.sv
// PHY address assignment and 100BASE-TX 4B/5B transmit encoder.
// Assumes MII nibbles arrive synchronous to clk_i, qualified by a strobe,
// and that the downstream scrambler may stall the code-group stream.
//
// Design decisions made here: the Avalon-MM register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module pae_top
  import pae_pkg::*;
#(
  parameter int FIFO_DEPTH = 16,
  parameter int ENC_PORT   = 0
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        strap_addr_sel_i,
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        mii_tx_valid_i,
  input  wire logic        mii_tx_en_i,
  input  wire logic        mii_tx_er_i,
  input  wire logic [3:0]  mii_txd_i,
  output logic             mii_tx_ready_o,
  output logic [4:0]       cg_o,
  output logic             cg_valid_o,
  input  wire logic        cg_ready_i,
  output logic [4:0]       phy_addr_v_o,
  output logic [4:0]       phy_addr_p1_o,
  output logic [4:0]       phy_addr_p2_o,
  output logic             spd100_o,
  output logic             fdx_o
);

  generate
    if (ENC_PORT < 0 || ENC_PORT > 1) begin : g_bad_port
      $error("pae_top: ENC_PORT must be 0 or 1");
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Functions
  function automatic logic [15:0] be_merge16(input logic [15:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0]  be);
    logic [15:0] res;
    res = old;
    if (be[0]) res[7:0]  = wd[7:0];
    if (be[1]) res[15:8] = wd[15:8];
    return res;
  endfunction

  function automatic logic is_data_cg(input logic [4:0] cg);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 16; i++) begin
      if (cg == CG_DATA[i]) hit = 1'b1;
    end
    return hit;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic              waitreq_r;
  logic [31:0]       rdata_r;
  logic [31:0]       rd_nxt;
  logic              req;
  logic              wr_en;
  logic              strap_taken_r;
  logic              strap_r;
  logic [4:0]        vaddr_r;
  logic [15:0]       bcr_r  [2];
  logic [4:0]        padr_r [2];
  logic              spd100;
  logic              fdx_r;
  logic              spd_r;
  pae_state_t        st_r;
  pae_state_t        st_nxt;
  pae_sym_t          kind;
  logic              adv;
  logic              pop;
  logic              emit;
  logic [4:0]        enc_code;
  logic              f_vld;
  logic [FE_W-1:0]   f_dat;
  logic              f_en;
  logic              f_er;
  logic [4:0]        cg_r;
  logic              cg_valid_r;

  //////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait cycle, then a one-cycle answer
  assign req   = avs_read_i || avs_write_i;
  assign wr_en = avs_write_i && !waitreq_r;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      waitreq_r <= 1'b1;
    end else if (!waitreq_r) begin
      waitreq_r <= 1'b1;
    end else if (req) begin
      waitreq_r <= 1'b0;
    end
  end

  always_comb begin
    rd_nxt = '0;
    case (avs_address_i)
      OFF_BCR[0]: rd_nxt[15:0] = bcr_r[0];
      OFF_BCR[1]: rd_nxt[15:0] = bcr_r[1];
      OFF_SMR[0]: rd_nxt[PADDR_W-1:0] = padr_r[0];
      OFF_SMR[1]: rd_nxt[PADDR_W-1:0] = padr_r[1];
      OFF_ADDR: begin
        rd_nxt[ADDR_V_LSB +: PADDR_W]  = vaddr_r;
        rd_nxt[ADDR_P1_LSB +: PADDR_W] = padr_r[0];
        rd_nxt[ADDR_P2_LSB +: PADDR_W] = padr_r[1];
        rd_nxt[ADDR_STRAP]             = strap_r;
      end
      OFF_STAT: begin
        rd_nxt[STAT_ST_LSB +: 2] = st_r;
        rd_nxt[STAT_RDY_BIT]     = mii_tx_ready_o;
      end
      default: rd_nxt = '0;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_r <= '0;
    end else if (req && waitreq_r) begin
      rdata_r <= rd_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Strap capture and default addresses
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      strap_taken_r <= 1'b0;
      strap_r       <= 1'b0;
    end else if (!strap_taken_r) begin
      strap_taken_r <= 1'b1;
      strap_r       <= strap_addr_sel_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      vaddr_r <= VADDR_BASE;
    end else if (!strap_taken_r) begin
      vaddr_r <= VADDR_BASE + {4'h0, strap_addr_sel_i};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Per-port control and special modes registers
  // Duplicate addresses are not detected; software keeps them apart.
  generate
    for (genvar p = 0; p < 2; p++) begin : g_port
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          bcr_r[p] <= BCR_RST;
        end else if (wr_en && avs_address_i == OFF_BCR[p]) begin
          bcr_r[p] <= be_merge16(bcr_r[p], avs_writedata_i,
                                 avs_byteenable_i);
        end
      end

      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          padr_r[p] <= PADDR_BASE[p];
        end else if (!strap_taken_r) begin
          padr_r[p] <= PADDR_BASE[p] + {4'h0, strap_addr_sel_i};
        end else if (wr_en && avs_address_i == OFF_SMR[p]
                     && avs_byteenable_i[0]) begin
          padr_r[p] <= avs_writedata_i[PADDR_W-1:0];
        end
      end
    end
  endgenerate

  assign spd100 = bcr_r[ENC_PORT][BCR_SPD_BIT];

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      spd_r <= BCR_RST[BCR_SPD_BIT];
      fdx_r <= BCR_RST[BCR_DPX_BIT];
    end else begin
      spd_r <= spd100;
      fdx_r <= bcr_r[ENC_PORT][BCR_DPX_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // MII intake FIFO
  pae_fifo #(
    .W (FE_W),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (mii_tx_valid_i),
    .in_ready_o  (mii_tx_ready_o),
    .in_data_i   ({mii_tx_en_i, mii_tx_er_i, mii_txd_i}),
    .out_valid_o (f_vld),
    .out_ready_i (pop),
    .out_data_o  (f_dat)
  );

  assign f_en = f_dat[FE_EN];
  assign f_er = f_dat[FE_ER];

  //////////////////////////////////////////////////////////////////////////////
  // Encoder sequencer
  assign adv = !cg_valid_r || cg_ready_i;

  always_comb begin
    st_nxt = st_r;
    pop    = 1'b0;
    emit   = 1'b0;
    kind   = SYM_I;
    if (adv) begin
      if (!spd100) begin
        // 10 Mbps: nibbles pass through unencoded
        st_nxt = ST_IDLE;
        pop    = f_vld;
        emit   = f_vld && f_en;
        kind   = SYM_RAW;
      end else begin
        unique case (st_r)
          ST_IDLE: begin
            emit = 1'b1;
            pop  = f_vld;
            if (f_vld && f_en) begin
              kind   = SYM_J;
              st_nxt = ST_SSD;
            end
          end
          ST_SSD: begin
            if (f_vld) begin
              pop    = 1'b1;
              emit   = 1'b1;
              kind   = SYM_K;
              st_nxt = ST_DATA;
            end
          end
          ST_DATA: begin
            if (f_vld) begin
              pop  = 1'b1;
              emit = 1'b1;
              if (!f_en) begin
                kind   = SYM_T;
                st_nxt = ST_ESD;
              end else if (f_er) begin
                kind = SYM_H;
              end else begin
                kind = SYM_DATA;
              end
            end
          end
          ST_ESD: begin
            emit   = 1'b1;
            kind   = SYM_R;
            st_nxt = ST_IDLE;
          end
        endcase
      end
    end
  end

  pae_enc u_enc (
    .kind_i (kind),
    .nib_i  (f_dat[3:0]),
    .code_o (enc_code)
  );

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= ST_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cg_r       <= CG_I;
      cg_valid_r <= 1'b0;
    end else if (adv) begin
      cg_r       <= enc_code;
      cg_valid_r <= emit;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign avs_readdata_o    = rdata_r;
  assign avs_waitrequest_o = waitreq_r;
  assign cg_o              = cg_r;
  assign cg_valid_o        = cg_valid_r;
  assign phy_addr_v_o      = vaddr_r;
  assign phy_addr_p1_o     = padr_r[0];
  assign phy_addr_p2_o     = padr_r[1];
  assign spd100_o          = spd_r;
  assign fdx_o             = fdx_r;

  //////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_data_in;
    adv && spd100 && st_r == ST_DATA && f_vld && f_en;
  endsequence

  sequence s_frame_start;
    adv && spd100 && st_r == ST_IDLE && f_vld && f_en;
  endsequence

  sequence s_ssd_pair;
    cg_valid_o && cg_o == CG_J ##1 cg_valid_o && cg_o == CG_K;
  endsequence

  property p_data_code;
    s_data_in and (adv && !f_er) |=> cg_valid_o
      && cg_o == CG_DATA[$past(f_dat[3:0])];
  endproperty
  a_data_code: assert property (p_data_code)
    else $error("data nibble encoded wrongly");

  property p_data_only;
    s_data_in and (adv && !f_er) |=> is_data_cg(cg_o);
  endproperty
  a_data_only: assert property (p_data_only)
    else $error("control code emitted for data");

  property p_defaults;
    $rose(strap_taken_r) |-> vaddr_r == VADDR_BASE + {4'h0, strap_r}
      && padr_r[0] == PADDR_BASE[0] + {4'h0, strap_r}
      && padr_r[1] == PADDR_BASE[1] + {4'h0, strap_r};
  endproperty
  a_defaults: assert property (p_defaults)
    else $error("default addresses do not follow strap");

  property p_addr_write;
    (wr_en && avs_address_i == OFF_SMR[1] && avs_byteenable_i[0])
      |=> phy_addr_p2_o == $past(avs_writedata_i[4:0]);
  endproperty
  a_addr_write: assert property (p_addr_write)
    else $error("port address write lost");

  property p_strap_hold;
    strap_taken_r |=> strap_taken_r && $stable(strap_r) && $stable(vaddr_r);
  endproperty
  a_strap_hold: assert property (p_strap_hold)
    else $error("strap value changed after reset");

  property p_raw_10m;
    (adv && !spd100) |=> !cg_valid_o || (cg_o == {1'b0, $past(f_dat[3:0])});
  endproperty
  a_raw_10m: assert property (p_raw_10m)
    else $error("10 Mbps path encoded a nibble");

  property p_bus_answer;
    (req && avs_waitrequest_o) |=> !avs_waitrequest_o ##1 avs_waitrequest_o;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("register answer not one cycle");

  property p_idle;
    (adv && spd100 && st_r == ST_IDLE && !(f_vld && f_en))
      |=> cg_valid_o && cg_o == CG_I;
  endproperty
  a_idle: assert property (p_idle)
    else $error("idle code-group missing");

  property p_ssd;
    s_frame_start |=> cg_o == CG_J && st_r == ST_SSD
      ##0 (cg_ready_i && f_vld && spd100) [*1] |=> cg_o == CG_K;
  endproperty
  a_ssd: assert property (p_ssd)
    else $error("start pair not J then K");

  property p_ssd_seq;
    (cg_valid_o && cg_o == CG_J && cg_ready_i && spd100 && f_vld)
      |-> ##0 s_ssd_pair;
  endproperty
  a_ssd_seq: assert property (p_ssd_seq)
    else $error("K does not follow J");

  property p_esd;
    (cg_valid_o && cg_o == CG_T && cg_ready_i && spd100)
      |=> cg_valid_o && cg_o == CG_R ##1 (st_r == ST_IDLE || !spd100);
  endproperty
  a_esd: assert property (p_esd)
    else $error("end pair not T then R");

  property p_err;
    s_data_in and (adv && f_er) |=> cg_valid_o && cg_o == CG_H;
  endproperty
  a_err: assert property (p_err)
    else $error("transmit error not marked");

endmodule
`default_nettype wire

// File: verification/pae_mac_model.sv
// MAC side model: offers MII transmit nibbles to the encoder.
// Assumes clock comes from the bench and ready from the design; entries are {en,er,nibble}.
`timescale 1ns/100ps
`default_nettype none
module pae_mac_model (
  input  wire logic clk_i,
  input  wire logic ready_i,
  output logic      valid_o,
  output logic      en_o,
  output logic      er_o,
  output logic [3:0] txd_o
);
  initial begin
    valid_o = 1'b0;
    en_o = 1'b0;
    er_o = 1'b0;
    txd_o = 4'h0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Holds each nibble until taken; random gaps mimic a slow MAC
  task automatic send(input logic [5:0] e[$]);
    int i;
    for (i = 0; i < e.size(); i++) begin
      while ($urandom_range(7) == 0) begin
        valid_o <= 1'b0;
        txd_o <= ~txd_o;
        @(posedge clk_i);
      end
      valid_o <= 1'b1;
      en_o <= e[i][5];
      er_o <= e[i][4];
      txd_o <= e[i][3:0];
      @(posedge clk_i);
      while (ready_i !== 1'b1) @(posedge clk_i);
    end
    valid_o <= 1'b0;
    en_o <= 1'b0;
    er_o <= 1'b0;
    txd_o <= ~e[e.size()-1][3:0];
  endtask
endmodule
`default_nettype wire

// File: verification/tb_top.sv
// Self-checking bench for the PHY address and 4B/5B encoder block.
// Assumes pae_top with a 16-deep FIFO and the MAC model beside it.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        strap_addr_sel_i = 1'b0;
  logic [7:0]  avs_address_i = 8'h00;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0]  avs_byteenable_i = 4'hF;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        mii_tx_valid_i, mii_tx_en_i, mii_tx_er_i;
  logic [3:0]  mii_txd_i;
  logic        mii_tx_ready_o, cg_valid_o, spd100_o, fdx_o;
  logic        cg_ready_i = 1'b0;
  logic [4:0]  cg_o, phy_addr_v_o, phy_addr_p1_o, phy_addr_p2_o;
  int          miscompares = 0;
  int          tests_run = 0;
  logic [4:0]  exp_q[$];
  logic        m10 = 1'b0;
  logic        stall = 1'b0;
  logic [31:0] q;
  localparam logic [4:0] DC [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B,
    5'h0E, 5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};

  always #5 clk_i = ~clk_i;

  pae_top #(.FIFO_DEPTH(16), .ENC_PORT(0)) pae_top_i (.clk_i, .rst_i, .strap_addr_sel_i,
    .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i,
    .avs_readdata_o, .avs_waitrequest_o, .mii_tx_valid_i, .mii_tx_en_i, .mii_tx_er_i,
    .mii_txd_i, .mii_tx_ready_o, .cg_o, .cg_valid_o, .cg_ready_i, .phy_addr_v_o,
    .phy_addr_p1_o, .phy_addr_p2_o, .spd100_o, .fdx_o);

  pae_mac_model pae_mac_model_i (.clk_i, .ready_i(mii_tx_ready_o), .valid_o(mii_tx_valid_i),
    .en_o(mii_tx_en_i), .er_o(mii_tx_er_i), .txd_o(mii_txd_i));

  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    tests_run++;
    if (seen !== ex) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, ex, seen);
    end
  endtask

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic av(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_read_i <= !wr;
    avs_write_i <= wr;
    @(posedge clk_i);
    while (avs_waitrequest_o !== 1'b0 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    if (n == 50) check("waitrequest", avs_waitrequest_o, 0);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic do_reset(input logic s);
    rst_i <= 1'b1;
    strap_addr_sel_i <= s;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    strap_addr_sel_i <= ~s;
    repeat (2) @(posedge clk_i);
  endtask

  task automatic chk_addr(input logic s, input logic [4:0] p1, input logic [4:0] p2);
    check("addr_v", phy_addr_v_o, {4'h0, s});
    check("addr_p1", phy_addr_p1_o, p1);
    check("addr_p2", phy_addr_p2_o, p2);
    av(1'b0, 8'h10, 32'h0);
    check("addr_reg", q, {7'h00, s, 3'h0, p2, 3'h0, p1, 3'h0, 4'h0, s});
  endtask

  task automatic drain();
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    check("drained", exp_q.size(), 0);
    repeat (8) @(posedge clk_i);
  endtask

  // Queues the expected code-groups, then hands the frame to the MAC
  task automatic frame(input int len);
    logic [5:0] e[$];
    logic [3:0] nb;
    logic       er;
    int         i;
    if (!m10) exp_q.push_back(5'h18);
    if (!m10) exp_q.push_back(5'h11);
    for (i = 0; i < len; i++) begin
      nb = 4'($urandom);
      er = (i > 1 && !m10 && $urandom_range(7) == 0);
      e.push_back({1'b1, er, nb});
      if (m10) exp_q.push_back({1'b0, nb});
      else if (i > 1) exp_q.push_back(er ? 5'h04 : DC[nb]);
    end
    if (!m10) exp_q.push_back(5'h0D);
    if (!m10) exp_q.push_back(5'h07);
    e.push_back({2'b00, 4'($urandom)});
    pae_mac_model_i.send(e);
    drain();
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Code-group scoreboard; idles before a frame start are skipped
  always @(posedge clk_i) begin
    if (!rst_i && cg_valid_o === 1'b1 && cg_ready_i === 1'b1) begin
      if (!(cg_o === 5'h1F && (m10 || exp_q.size() == 0 || exp_q[0] === 5'h18))) begin
        if (exp_q.size() == 0) begin
          check("idle_cg", cg_o, 5'h1F);
        end else begin
          check("cg", cg_o, exp_q.pop_front());
        end
      end
    end
    cg_ready_i <= stall ? 1'b0 : ($urandom_range(3) != 0);
  end

  initial begin
    repeat (60000) @(posedge clk_i);
    check("watchdog", 0, 1);
    give_verdict();
  end

  initial begin
    logic [4:0] p1;
    logic [4:0] p2;
    logic       full;
    void'($urandom(32'h58003557));
    full = 1'b0;
    @(posedge clk_i);
    do_reset(1'b0);
    chk_addr(1'b0, 5'h01, 5'h02);
    av(1'b0, 8'h00, 32'h0);
    check("bcr", q, 32'h3100);
    check("spd_fdx", {spd100_o, fdx_o}, 2'b11);
    av(1'b0, 8'h20, 32'h0);
    check("unmapped", q, 32'h0);
    p1 = 5'($urandom_range(4, 15));
    p2 = 5'($urandom_range(16, 31));
    av(1'b1, 8'h04, {27'h0, p1});
    av(1'b1, 8'h0C, {27'h0, p2});
    av(1'b1, 8'h20, 32'hFFFF);
    chk_addr(1'b0, p1, p2);
    // Special modes write without the low byte lane must leave the address alone
    avs_byteenable_i <= 4'hE;
    av(1'b1, 8'h04, 32'h1F);
    avs_byteenable_i <= 4'hF;
    check("p1_be", phy_addr_p1_o, p1);
    frame(2);
    for (int k = 0; k < 10; k++) frame(3 + $urandom_range(17));
    stall <= 1'b1;
    fork
      frame(24);
      begin
        repeat (60) begin
          @(posedge clk_i);
          if (mii_tx_ready_o === 1'b0) full = 1'b1;
        end
        check("fifo_full", full, 1'b1);
        stall <= 1'b0;
      end
    join
    av(1'b1, 8'h00, 32'h0100);
    repeat (2) @(posedge clk_i);
    check("spd_fdx", {spd100_o, fdx_o}, 2'b01);
    m10 = 1'b1;
    frame(6);
    av(1'b1, 8'h00, 32'h2000);
    repeat (2) @(posedge clk_i);
    m10 = 1'b0;
    check("spd_fdx", {spd100_o, fdx_o}, 2'b10);
    frame(5);
    av(1'b0, 8'h14, 32'h0);
    check("stat", q & 32'h13, 32'h10);
    do_reset(1'b1);
    chk_addr(1'b1, 5'h02, 5'h03);
    frame(8);
    give_verdict();
  end
endmodule
`default_nettype wire
